// ===== include/emf_pkg.sv
// constants and carriers for the mac filter, status and clock config block
package emf_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [12:0] EMF_OFS_REFOUT = 13'h0000;
  localparam logic [12:0] EMF_OFS_OSC = 13'h0004;
  localparam logic [12:0] EMF_OFS_GATE = 13'h0008;
  localparam logic [12:0] EMF_OFS_PHYIF = 13'h000c;
  localparam logic [12:0] EMF_OFS_PD = 13'h0010;
  localparam logic [12:0] EMF_OFS_MACCFG = 13'h1000;
  localparam logic [12:0] EMF_OFS_S8HI = 13'h1078;
  localparam logic [12:0] EMF_OFS_S8LO = 13'h107c;
  localparam logic [12:0] EMF_OFS_STAT = 13'h10d8;
  localparam logic [12:0] EMF_OFS_WDOG = 13'h10dc;

  // ****************************************
  // writable bits per register, reset value
  // ****************************************
  localparam logic [31:0] EMF_MSK_REFOUT = 32'h0000_0fff;
  localparam logic [31:0] EMF_MSK_OSC = 32'h01ff_ffff;
  localparam logic [31:0] EMF_MSK_GATE = 32'h0000_000f;
  localparam logic [31:0] EMF_MSK_PHYIF = 32'h0000_0007;
  localparam logic [31:0] EMF_MSK_PD = 32'h0000_0003;
  localparam logic [31:0] EMF_MSK_MACCFG = 32'h0090_0000;
  localparam logic [31:0] EMF_MSK_S8HI = 32'hff00_ffff;
  localparam logic [31:0] EMF_MSK_WDOG = 32'h0001_3fff;
  localparam logic [31:0] EMF_RST_VAL = 32'h0000_0000;

  // ****************************************
  // field positions
  // ****************************************
  localparam int EMF_S8_ON_BIT = 31;
  localparam int EMF_S8_SENDER_BIT = 30;
  localparam int EMF_S8_MASK_LSB = 24;
  localparam int EMF_CFG_WD_BIT = 23;
  localparam int EMF_CFG_JE_BIT = 20;
  localparam int EMF_WD_PWE_BIT = 16;
  localparam int EMF_STAT_DUPLEX_BIT = 0;
  localparam int EMF_STAT_SPEED_LSB = 1;
  localparam int EMF_STAT_JABBER_BIT = 3;
  localparam int EMF_GATE_EXT_BIT = 0;
  localparam int EMF_GATE_INT_BIT = 1;
  localparam int EMF_GATE_TX_BIT = 2;
  localparam int EMF_GATE_RX_BIT = 3;
  localparam int EMF_PD_TX_BIT = 0;
  localparam int EMF_PD_RX_BIT = 1;
  localparam int EMF_OSC_SEL_BIT = 24;
  localparam int EMF_DIV_W = 6;

  // ****************************************
  // encodings and limits
  // ****************************************
  localparam logic [2:0] EMF_PHY_MII = 3'h0;
  localparam logic [2:0] EMF_PHY_RMII = 3'h4;
  localparam logic [1:0] EMF_SPD_2M5 = 2'h0;
  localparam logic [1:0] EMF_SPD_25M = 2'h1;
  localparam logic [1:0] EMF_SPD_125M = 2'h2;
  localparam logic [13:0] EMF_GUARD_STD = 14'h0800;
  localparam logic [13:0] EMF_GUARD_JUMBO = 14'h2800;
  localparam logic [13:0] EMF_CNT_MAX = 14'h3fff;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [12:0] paddr;
    logic [31:0] pwdata;
  } emf_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } emf_apb_rsp_t;

  typedef struct packed {
    logic addr_vld;
    logic [47:0] da;
    logic [47:0] sa;
    logic frame_on;
    logic byte_stb;
  } emf_rx_t;

endpackage : emf_pkg

// ===== verilog/emf_top.sv
// mac slot-8 filter, link status, rx watchdog and clock config block
`timescale 1ns/1ps
module emf_top (
  input wire logic sys_clk_i, // 200 MHz clock
  input wire logic rstn_i, // sync reset, active low
  input wire emf_pkg::emf_apb_req_t apb_req_i, // apb request
  output emf_pkg::emf_apb_rsp_t apb_rsp_o, // apb answer
  input wire emf_pkg::emf_rx_t rx_i, // receive path info
  input wire logic [1:0] link_speed_i, // phy speed pins
  input wire logic link_duplex_i, // phy duplex pin
  input wire logic jabber_i, // jabber timeout pin
  input wire logic phy_ref_clk_i, // phy reference clock pin
  output logic slot8_hit_o, // slot 8 match pulse
  output logic rx_cut_o, // frame cut, level
  output logic rx_err_o, // error frame pulse
  output logic ref_clk_o, // rmii reference out
  output logic rx_clk_o, // gated rx clock
  output logic tx_clk_o, // gated tx clock
  output logic mii_mode_o, // mii selected
  output logic rmii_mode_o, // rmii selected
  output logic tx_ram_pd_o, // tx ram power down
  output logic rx_ram_pd_o // rx ram power down
);
  import emf_pkg::*;
  // ****************************************
  // declarations
  // ****************************************
  logic [31:0] refout_ff;
  logic [31:0] osc_ff;
  logic [31:0] gate_ff;
  logic [31:0] phyif_ff;
  logic [31:0] pd_ff;
  logic [31:0] cfg_ff;
  logic [31:0] s8hi_ff;
  logic [31:0] s8lo_ff;
  logic [31:0] wdog_ff;
  logic pready_ff;
  logic slverr_ff;
  logic [31:0] prdata_ff;
  logic [4:0] pin_s1_ff;
  logic [4:0] pin_s2_ff;
  logic hit_ff;
  logic [13:0] gcnt_ff;
  logic cut_ff;
  logic err_ff;
  logic ref_ff;
  logic rxc_ff;
  logic txc_ff;
  logic mii_ff;
  logic rmii_ff;
  logic txpd_ff;
  logic rxpd_ff;

  // ****************************************
  // apb decode
  // ****************************************
  // address match per register
  wire [12:0] adr = apb_req_i.paddr;
  wire hit_refout = (adr == EMF_OFS_REFOUT);
  wire hit_osc = (adr == EMF_OFS_OSC);
  wire hit_gate = (adr == EMF_OFS_GATE);
  wire hit_phyif = (adr == EMF_OFS_PHYIF);
  wire hit_pd = (adr == EMF_OFS_PD);
  wire hit_cfg = (adr == EMF_OFS_MACCFG);
  wire hit_s8hi = (adr == EMF_OFS_S8HI);
  wire hit_s8lo = (adr == EMF_OFS_S8LO);
  wire hit_stat = (adr == EMF_OFS_STAT);
  wire hit_wdog = (adr == EMF_OFS_WDOG);
  wire hit_any = hit_refout | hit_osc | hit_gate | hit_phyif | hit_pd | hit_cfg
    | hit_s8hi | hit_s8lo | hit_stat | hit_wdog;
  // setup phase and completing write
  wire setup = apb_req_i.psel & ~apb_req_i.penable;
  wire wr_en = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & pready_ff;
  wire [31:0] wd = apb_req_i.pwdata;

  // ****************************************
  // live link status
  // ****************************************
  // synchronised pins: speed, duplex, jabber, phy ref
  wire [1:0] speed_s = pin_s2_ff[2:1];
  wire duplex_s = pin_s2_ff[0];
  wire jabber_s = pin_s2_ff[3];
  wire phyref_s = pin_s2_ff[4];
  // status word rebuilt every cycle, no storage
  logic [31:0] stat_w;
  always_comb
  begin
    stat_w = EMF_RST_VAL;
    stat_w[EMF_STAT_DUPLEX_BIT] = duplex_s;
    stat_w[EMF_STAT_SPEED_LSB +: 2] = speed_s;
    stat_w[EMF_STAT_JABBER_BIT] = jabber_s;
  end

  // ****************************************
  // read mux
  // ****************************************
  // status is read from the synchronised pins, never written
  wire [31:0] rd_mux = hit_refout ? refout_ff :
    hit_osc ? osc_ff :
    hit_gate ? gate_ff :
    hit_phyif ? phyif_ff :
    hit_pd ? pd_ff :
    hit_cfg ? cfg_ff :
    hit_s8hi ? s8hi_ff :
    hit_s8lo ? s8lo_ff :
    hit_stat ? stat_w :
    hit_wdog ? wdog_ff : EMF_RST_VAL;

  // ****************************************
  // apb answer
  // ****************************************
  // answer prepared in setup, ready in first access cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      pready_ff <= 1'b0;
      slverr_ff <= 1'b0;
      prdata_ff <= EMF_RST_VAL;
    end
    else
    begin
      pready_ff <= setup;
      slverr_ff <= setup & ~hit_any;
      prdata_ff <= (setup & ~apb_req_i.pwrite) ? rd_mux : EMF_RST_VAL;
    end
  end
  assign apb_rsp_o = {pready_ff, slverr_ff, prdata_ff};

  // ****************************************
  // register file
  // ****************************************
  // writes land at the completing access edge, status has no store
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      refout_ff <= EMF_RST_VAL;
      osc_ff <= EMF_RST_VAL;
      gate_ff <= EMF_RST_VAL;
      phyif_ff <= EMF_RST_VAL;
      pd_ff <= EMF_RST_VAL;
      cfg_ff <= EMF_RST_VAL;
      s8hi_ff <= EMF_RST_VAL;
      s8lo_ff <= EMF_RST_VAL;
      wdog_ff <= EMF_RST_VAL;
    end
    else if (wr_en)
    begin
      if (hit_refout) refout_ff <= wd & EMF_MSK_REFOUT;
      if (hit_osc) osc_ff <= wd & EMF_MSK_OSC;
      if (hit_gate) gate_ff <= wd & EMF_MSK_GATE;
      if (hit_phyif) phyif_ff <= wd & EMF_MSK_PHYIF;
      if (hit_pd) pd_ff <= wd & EMF_MSK_PD;
      if (hit_cfg) cfg_ff <= wd & EMF_MSK_MACCFG;
      if (hit_s8hi) s8hi_ff <= wd & EMF_MSK_S8HI;
      if (hit_s8lo) s8lo_ff <= wd;
      if (hit_wdog) wdog_ff <= wd & EMF_MSK_WDOG;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  // two stages before any logic reads the pins
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      pin_s1_ff <= 5'h00;
      pin_s2_ff <= 5'h00;
    end
    else
    begin
      pin_s1_ff <= {phy_ref_clk_i, jabber_i, link_speed_i, link_duplex_i};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // ****************************************
  // slot 8 address filter
  // ****************************************
  wire s8_on = s8hi_ff[EMF_S8_ON_BIT];
  wire s8_sender = s8hi_ff[EMF_S8_SENDER_BIT];
  wire [5:0] s8_skip = s8hi_ff[EMF_S8_MASK_LSB +: 6];
  wire [47:0] s8_addr = {s8hi_ff[15:0], s8lo_ff};
  wire [47:0] s8_cmp = s8_sender ? rx_i.sa : rx_i.da;
  wire [5:0] byte_ok;
  // per byte compare, a set skip bit forces a match
  genvar b;
  generate
    for (b = 0; b < 6; b++)
    begin : g_byte
      assign byte_ok[b] = s8_skip[b] | (s8_addr[8*b +: 8] == s8_cmp[8*b +: 8]);
    end
  endgenerate
  // disabled slot never matches
  wire nxt_hit = rx_i.addr_vld & s8_on & (&byte_ok);
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i) hit_ff <= 1'b0;
    else hit_ff <= nxt_hit;
  end

  // ****************************************
  // receive watchdog
  // ****************************************
  wire wd_off = cfg_ff[EMF_CFG_WD_BIT];
  wire jumbo_on = cfg_ff[EMF_CFG_JE_BIT];
  wire prog_guard_bit = wdog_ff[EMF_WD_PWE_BIT];
  // limit choice: programmed field or fixed standard/jumbo
  wire [13:0] fix_lim = jumbo_on ? EMF_GUARD_JUMBO : EMF_GUARD_STD;
  wire [13:0] g_lim = prog_guard_bit ? wdog_ff[13:0] : fix_lim;
  // byte beyond limit while guard active
  wire over = rx_i.frame_on & rx_i.byte_stb & ~wd_off & ~cut_ff & (gcnt_ff >= g_lim);
  // counter saturates so very long frames stay caught
  wire [13:0] nxt_gcnt = ~rx_i.frame_on ? 14'h0000 :
    (rx_i.byte_stb & (gcnt_ff != EMF_CNT_MAX)) ? gcnt_ff + 14'h0001 : gcnt_ff;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      gcnt_ff <= 14'h0000;
      cut_ff <= 1'b0;
      err_ff <= 1'b0;
    end
    else
    begin
      gcnt_ff <= nxt_gcnt;
      cut_ff <= rx_i.frame_on & (cut_ff | over);
      err_ff <= over;
    end
  end

  // ****************************************
  // clock dividers
  // ****************************************
  // speed picks fast or slow pair for the mac clock divider
  wire fast = (speed_s != EMF_SPD_2M5);
  wire [5:0] mac_whole = fast ? osc_ff[12 +: EMF_DIV_W] : osc_ff[0 +: EMF_DIV_W];
  wire [5:0] mac_half = fast ? osc_ff[18 +: EMF_DIV_W] : osc_ff[6 +: EMF_DIV_W];
  wire [5:0] div_whole [2];
  wire [5:0] div_half [2];
  wire [1:0] div_out;
  assign div_whole[0] = refout_ff[0 +: EMF_DIV_W];
  assign div_half[0] = refout_ff[6 +: EMF_DIV_W];
  assign div_whole[1] = mac_whole;
  assign div_half[1] = mac_half;
  // period whole+1 cycles, high for the first half cycles
  genvar k;
  generate
    for (k = 0; k < 2; k++)
    begin : g_div
      logic [5:0] cnt_ff;
      logic out_ff;
      wire wrap = (cnt_ff >= div_whole[k]);
      always_ff @(posedge sys_clk_i)
      begin
        if (!rstn_i)
        begin
          cnt_ff <= 6'h00;
          out_ff <= 1'b0;
        end
        else
        begin
          cnt_ff <= wrap ? 6'h00 : cnt_ff + 6'h01;
          out_ff <= (cnt_ff < div_half[k]);
        end
      end
      assign div_out[k] = out_ff;
    end
  endgenerate

  // ****************************************
  // clock source select and gating
  // ****************************************
  wire rmii = (phyif_ff[2:0] == EMF_PHY_RMII);
  wire from_phy = osc_ff[EMF_OSC_SEL_BIT];
  // rmii source enables qualify the selected source
  wire ext_path = from_phy & gate_ff[EMF_GATE_EXT_BIT];
  wire int_path = ~from_phy & gate_ff[EMF_GATE_INT_BIT];
  wire nxt_ref = rmii & (ext_path ? phyref_s : (int_path & div_out[0]));
  wire mac_src = (rmii & ext_path) ? phyref_s : div_out[1];
  // registered outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      ref_ff <= 1'b0;
      rxc_ff <= 1'b0;
      txc_ff <= 1'b0;
      mii_ff <= 1'b0;
      rmii_ff <= 1'b0;
      txpd_ff <= 1'b0;
      rxpd_ff <= 1'b0;
    end
    else
    begin
      ref_ff <= nxt_ref;
      rxc_ff <= gate_ff[EMF_GATE_RX_BIT] & mac_src;
      txc_ff <= gate_ff[EMF_GATE_TX_BIT] & mac_src;
      mii_ff <= (phyif_ff[2:0] == EMF_PHY_MII);
      rmii_ff <= rmii;
      txpd_ff <= pd_ff[EMF_PD_TX_BIT];
      rxpd_ff <= pd_ff[EMF_PD_RX_BIT];
    end
  end
  assign slot8_hit_o = hit_ff;
  assign rx_cut_o = cut_ff;
  assign rx_err_o = err_ff;
  assign ref_clk_o = ref_ff;
  assign rx_clk_o = rxc_ff;
  assign tx_clk_o = txc_ff;
  assign mii_mode_o = mii_ff;
  assign rmii_mode_o = rmii_ff;
  assign tx_ram_pd_o = txpd_ff;
  assign rx_ram_pd_o = rxpd_ff;
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // disabled slot gives no hit
  filter_off_a: assert property (
    rx_i.addr_vld && !s8_on |=> !slot8_hit_o)
    else $error("hit with slot disabled");
  // exact destination match gives a hit
  filter_hit_a: assert property (
    rx_i.addr_vld && s8_on && !s8_sender && (s8_skip == 6'h00)
    && (rx_i.da == {s8hi_ff[15:0], s8lo_ff}) |=> slot8_hit_o)
    else $error("destination match missed");
  // sender mode ignores destination field
  sender_sel_a: assert property (
    rx_i.addr_vld && s8_on && s8_sender && (s8_skip == 6'h00)
    && (rx_i.sa != {s8hi_ff[15:0], s8lo_ff}) |=> !slot8_hit_o)
    else $error("source mismatch gave hit");
  // all bytes skipped on an enabled slot always matches
  mask_all_a: assert property (
    rx_i.addr_vld && s8_on && (&s8_skip) |=> slot8_hit_o)
    else $error("fully masked slot missed");
  // status read returns live pins of setup cycle
  stat_rd_a: assert property (
    setup && !apb_req_i.pwrite && hit_stat
    |=> apb_rsp_o.prdata == {28'h000_0000, $past(jabber_s), $past(speed_s), $past(duplex_s)})
    else $error("status read mismatch");
  // standard limit with guard on and no override: flag and cut together
  guard_std_a: assert property (
    rx_i.frame_on && rx_i.byte_stb && !cut_ff && !wd_off && !prog_guard_bit && !jumbo_on
    && (gcnt_ff == EMF_GUARD_STD) |=> rx_err_o && rx_cut_o)
    else $error("standard limit not enforced");
  // guard disabled never flags
  guard_off_a: assert property (
    wd_off |=> !rx_err_o)
    else $error("flag with guard disabled");
  // cut holds until frame ends
  guard_cut_a: assert property (
    rx_err_o && rx_i.frame_on |-> rx_cut_o ##1 (rx_cut_o || !$past(rx_i.frame_on)))
    else $error("cut not held");
  // rmii select reaches output two edges after the write
  phy_type_a: assert property (
    wr_en && hit_phyif && (wd[2:0] == EMF_PHY_RMII) |=> ##1 rmii_mode_o && !mii_mode_o)
    else $error("rmii select lost");
  // tx ram power down follows write
  ram_pd_a: assert property (
    wr_en && hit_pd && wd[EMF_PD_TX_BIT] |=> ##1 tx_ram_pd_o)
    else $error("tx ram not powered down");
  // gated rx clock stays low
  gate_off_a: assert property (
    !gate_ff[EMF_GATE_RX_BIT] |=> !rx_clk_o)
    else $error("rx clock ran while gated");
  // phy source passes the synchronised phy clock
  ref_sel_a: assert property (
    rmii && ext_path |=> ref_clk_o == $past(phyref_s))
    else $error("phy reference not passed");
endmodule : emf_top

// ===== tb/emf_phy_model.sv
// behavioural phy: link status pins and a free-running reference clock
`timescale 1ns/1ps
module emf_phy_model #(
  parameter real REF_HALF = 20.0 // half period of the phy clock, ns
) (
  input wire logic [1:0] speed_i, // commanded link speed
  input wire logic duplex_i, // commanded duplex
  input wire logic jabber_i, // commanded jabber event
  output logic [1:0] link_speed_o, // speed pins
  output logic link_duplex_o, // duplex pin
  output logic jabber_o, // jabber pin
  output logic ref_clk_o // phy reference clock
);
  // status pins follow the commanded link state
  assign link_speed_o = speed_i;
  assign link_duplex_o = duplex_i;
  assign jabber_o = jabber_i;
  // output clock runs free, phase unrelated to the system clock
  initial
  begin
    ref_clk_o = 1'b0;
    #7.3;
    forever #(REF_HALF) ref_clk_o = ~ref_clk_o;
  end
endmodule : emf_phy_model

// ===== tb/tb_emf_top.sv
// self-checking bench for the slot-8 filter, status, watchdog and clock block
`timescale 1ns/1ps
module tb_emf_top;
  import emf_pkg::*;
  logic sys_clk_i;
  logic rstn_i;
  emf_apb_req_t apb_req;
  emf_apb_rsp_t apb_rsp;
  emf_rx_t rx;
  logic [1:0] spd;
  logic dup, jab, phy_clk, jab_pin, dup_pin, hit, cut, rerr, refc, rxc, txc, mii, rmii, tpd, rpd;
  logic [1:0] spd_pin;
  logic p_ref, p_rx, p_tx;
  logic [31:0] d;
  logic e;
  int err_total, n_tests, n_err, e_ref, e_rx, e_tx, h_ref;
  logic [12:0] ofs [9] = '{EMF_OFS_REFOUT, EMF_OFS_OSC, EMF_OFS_GATE, EMF_OFS_PHYIF,
    EMF_OFS_PD, EMF_OFS_MACCFG, EMF_OFS_S8HI, EMF_OFS_S8LO, EMF_OFS_WDOG};
  logic [31:0] msk [9] = '{EMF_MSK_REFOUT, EMF_MSK_OSC, EMF_MSK_GATE, EMF_MSK_PHYIF,
    EMF_MSK_PD, EMF_MSK_MACCFG, EMF_MSK_S8HI, 32'hffff_ffff, EMF_MSK_WDOG};
  localparam logic [47:0] ADR = 48'h0123_4567_89ab;

  // 200 MHz system clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  emf_top u_emf_top (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .apb_req_i(apb_req),
    .apb_rsp_o(apb_rsp), .rx_i(rx), .link_speed_i(spd_pin), .link_duplex_i(dup_pin),
    .jabber_i(jab_pin), .phy_ref_clk_i(phy_clk), .slot8_hit_o(hit), .rx_cut_o(cut),
    .rx_err_o(rerr), .ref_clk_o(refc), .rx_clk_o(rxc), .tx_clk_o(txc),
    .mii_mode_o(mii), .rmii_mode_o(rmii), .tx_ram_pd_o(tpd), .rx_ram_pd_o(rpd));

  emf_phy_model u_emf_phy_model (.speed_i(spd), .duplex_i(dup), .jabber_i(jab),
    .link_speed_o(spd_pin), .link_duplex_o(dup_pin), .jabber_o(jab_pin),
    .ref_clk_o(phy_clk));

  // error pulses, reference high cycles and clock rising edges, never cleared
  always @(posedge sys_clk_i)
  begin
    p_ref <= refc;
    p_rx <= rxc;
    p_tx <= txc;
    if (rerr === 1'b1) n_err <= n_err + 1;
    if (refc === 1'b1) h_ref <= h_ref + 1;
    if (refc === 1'b1 && p_ref === 1'b0) e_ref <= e_ref + 1;
    if (rxc === 1'b1 && p_rx === 1'b0) e_rx <= e_rx + 1;
    if (txc === 1'b1 && p_tx === 1'b0) e_tx <= e_tx + 1;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  // edge counts may be off by one where the window cuts a period; zero is exact
  task automatic chk_cnt(input int got, input int exp);
    n_tests++;
    if (got < exp - 1 || got > exp + 1 || (exp == 0 && got != 0))
    begin
      err_total++;
      $display("mismatch at %0t: %0d edges, expected %0d", $time, got, exp);
    end
  endtask : chk_cnt

  // one apb transfer; waits for pready, request held until it is seen
  task automatic apb_xfer(input logic w, input logic [12:0] a, input logic [31:0] wd);
    int k;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge sys_clk_i);
    apb_req.penable <= 1'b1;
    @(posedge sys_clk_i);
    k = 0;
    while (apb_rsp.pready !== 1'b1 && k < 20)
    begin
      @(posedge sys_clk_i);
      k++;
    end
    d = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
    if (k >= 20)
    begin
      err_total++;
      summarize();
    end
    else
      @(posedge sys_clk_i);
  endtask : apb_xfer

  task automatic send(input logic [47:0] da, input logic [47:0] sa, input logic exp);
    rx.addr_vld <= 1'b1;
    rx.da <= da;
    rx.sa <= sa;
    @(posedge sys_clk_i);
    rx.addr_vld <= 1'b0;
    @(posedge sys_clk_i);
    chk_val({31'h0, hit}, {31'h0, exp});
  endtask : send

  task automatic frame(input int n, input int exp);
    int b;
    b = n_err;
    rx.frame_on <= 1'b1;
    @(posedge sys_clk_i);
    rx.byte_stb <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    rx.byte_stb <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk_val({31'h0, cut}, exp);
    rx.frame_on <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk_val({31'h0, cut}, 32'h0000_0000);
    chk_val(n_err - b, exp);
  endtask : frame

  task automatic edges(input int cyc, input int er, input int ex, input int et, input int eh);
    int br, bx, bt, bh;
    repeat (4) @(posedge sys_clk_i);
    br = e_ref;
    bx = e_rx;
    bt = e_tx;
    bh = h_ref;
    repeat (cyc) @(posedge sys_clk_i);
    chk_cnt(e_ref - br, er);
    chk_cnt(e_rx - bx, ex);
    chk_cnt(e_tx - bt, et);
    chk_cnt(h_ref - bh, eh);
  endtask : edges

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rstn_i = 1'b0;
    apb_req = '0;
    rx = '0;
    {spd, dup, jab} = 4'h0;
    {err_total, n_tests, n_err, e_ref, e_rx, e_tx, h_ref} = '0;
    repeat (6) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    // reset values, writable bits, unmapped address
    for (int i = 0; i < 9; i++)
    begin
      apb_xfer(1'b0, ofs[i], 32'h0);
      chk_val(d, EMF_RST_VAL);
      apb_xfer(1'b1, ofs[i], 32'hffff_ffff);
      apb_xfer(1'b0, ofs[i], 32'h0);
      chk_val(d, msk[i]);
      apb_xfer(1'b1, ofs[i], EMF_RST_VAL);
    end
    apb_xfer(1'b0, 13'h0020, 32'h0);
    chk_val({e, d[30:0]}, 32'h8000_0000);
    // live status, writes ignored
    for (int s = 0; s < 3; s++)
    begin
      spd <= s[1:0];
      dup <= s[0];
      jab <= s[1];
      repeat (4) @(posedge sys_clk_i);
      apb_xfer(1'b1, EMF_OFS_STAT, 32'hffff_ffff);
      apb_xfer(1'b0, EMF_OFS_STAT, 32'h0);
      chk_val(d, {28'h0, s[1], s[1:0], s[0]});
    end
    spd <= 2'b00;
    // slot 8 filter
    apb_xfer(1'b1, EMF_OFS_S8LO, 32'h4567_89ab);
    apb_xfer(1'b1, EMF_OFS_S8HI, 32'h0000_0123);
    send(ADR, 48'h0, 1'b0);
    apb_xfer(1'b1, EMF_OFS_S8HI, 32'h8000_0123);
    send(ADR, 48'h0, 1'b1);
    send(48'h0, ADR, 1'b0);
    apb_xfer(1'b1, EMF_OFS_S8HI, 32'hc000_0123);
    send(48'h0, ADR, 1'b1);
    send(ADR, 48'h0, 1'b0);
    apb_xfer(1'b1, EMF_OFS_S8HI, 32'ha100_0123);
    send(ADR ^ 48'hff00_0000_00ff, 48'h0, 1'b1);
    send(ADR ^ 48'h0000_ff00_0000, 48'h0, 1'b0);
    apb_xfer(1'b1, EMF_OFS_S8HI, 32'hbf00_0000);
    send(48'h0, 48'h0, 1'b1);
    // receive watchdog limits
    apb_xfer(1'b1, EMF_OFS_WDOG, 32'h0001_0002);
    frame(2, 0);
    frame(3, 1);
    apb_xfer(1'b1, EMF_OFS_MACCFG, 32'h0080_0000);
    frame(3, 0);
    apb_xfer(1'b1, EMF_OFS_MACCFG, 32'h0);
    apb_xfer(1'b1, EMF_OFS_WDOG, 32'h0000_0002);
    frame(2048, 0);
    frame(2049, 1);
    apb_xfer(1'b1, EMF_OFS_MACCFG, 32'h0010_0000);
    frame(2049, 0);
    frame(10241, 1);
    apb_xfer(1'b1, EMF_OFS_MACCFG, 32'h0);
    // interface select and ram power-down, outputs settle two edges after the write
    apb_xfer(1'b1, EMF_OFS_PHYIF, 32'h4);
    apb_xfer(1'b1, EMF_OFS_PD, 32'h1);
    @(posedge sys_clk_i);
    chk_val({28'h0, mii, rmii, tpd, rpd}, 32'h0000_0006);
    apb_xfer(1'b1, EMF_OFS_PHYIF, 32'h0);
    apb_xfer(1'b1, EMF_OFS_PD, 32'h2);
    @(posedge sys_clk_i);
    chk_val({28'h0, mii, rmii, tpd, rpd}, 32'h0000_0009);
    // divided and gated clocks, last count is reference high cycles
    apb_xfer(1'b1, EMF_OFS_OSC, 32'h0010_7041);
    apb_xfer(1'b1, EMF_OFS_GATE, 32'h8);
    edges(400, 0, 200, 0, 0);
    spd <= 2'b01;
    apb_xfer(1'b1, EMF_OFS_GATE, 32'hc);
    edges(400, 0, 50, 50, 0);
    apb_xfer(1'b1, EMF_OFS_GATE, 32'h0);
    edges(100, 0, 0, 0, 0);
    apb_xfer(1'b1, EMF_OFS_PHYIF, 32'h4);
    apb_xfer(1'b1, EMF_OFS_REFOUT, 32'h0000_0083);
    apb_xfer(1'b1, EMF_OFS_GATE, 32'h2);
    edges(400, 100, 0, 0, 200);
    apb_xfer(1'b1, EMF_OFS_OSC, 32'h0110_7041);
    edges(100, 0, 0, 0, 0);
    apb_xfer(1'b1, EMF_OFS_GATE, 32'h9);
    edges(400, 50, 50, 0, 200);
    summarize();
  end
endmodule : tb_emf_top
